// [core/fim_regs.svh]
// How it works
// - commands ignored until configuration bit 6 set
// - key A2H then DFH precedes each command
// - command without fresh key sequence is dropped
// - command register write starts the operation
// - locked page refuses sector erase, program, verify
// - core held stopped while an operation runs
// - timing oscillator on only during program/erase
// - opcode 01H, data 55H, pin low: chip erase
// - chip erase clears locks, options, boot vector
// - opcode 0DH, data 55H: partition 0 erase
// - opcode 0BH erases addressed 128-byte sector
// - opcode 0EH programs data byte at address
// - opcode 0CH reads byte after prior finishes
// - opcode 03H programs page bits, only downward
// - erased page bits all ones, meaning unlocked
// - decode 05H, 08H E1H/E2H, 09H options
// - opcode 08H with E0H selects six-clock cycles
// - signature bytes at 30H, 31H, 32H
`ifndef FIM_REGS_SVH
`define FIM_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define FIM_KEY1_OFS 8'h97
`define FIM_CMD_OFS 8'hB2
`define FIM_KEY2_OFS 8'hC4
`define FIM_CFG_OFS 8'hB1
`define FIM_DATA_OFS 8'hB3
`define FIM_AH_OFS 8'hB4
`define FIM_AL_OFS 8'hB5
`define FIM_STAT_OFS 8'hB6
// ****************************************
// fields and values
// ****************************************
`define FIM_CFG_IAP_BIT 6
`define FIM_STAT_BUSY_BIT 0
`define FIM_STAT_REFUSED_BIT 1
`define FIM_KEY1_VAL 8'hA2
`define FIM_KEY2_VAL 8'hDF
`define FIM_ERASE_KEY 8'h55
`define FIM_LOCK_ERASED 8'hFF
`define FIM_SECTOR_MASK 8'h80
`define FIM_PART1_BASE 16'h4000
`define FIM_BOOT_DEFAULT 16'h4000
`define FIM_OP_CHIP 7'h01
`define FIM_OP_SECURE 7'h03
`define FIM_OP_EXTDIS 7'h05
`define FIM_OP_BOOTSEL 7'h08
`define FIM_OP_USERVEC 7'h09
`define FIM_OP_SECTOR 7'h0B
`define FIM_OP_VERIFY 7'h0C
`define FIM_OP_PART0 7'h0D
`define FIM_OP_PROG 7'h0E
`define FIM_AH_PAGE0 8'h90
`define FIM_AH_PAGE4 8'h94
`define FIM_AH_EXT0 8'hB0
`define FIM_AH_EXT3 8'hB3
`define FIM_AH_CLKDBL 8'hE0
`define FIM_AH_BOOTUSER 8'hE1
`define FIM_AH_BOOTZERO 8'hE2
`define FIM_AH_USERVEC 8'hF0
`define FIM_ID_MFR_ADDR 8'h30
`define FIM_ID_DEV_ADDR 8'h31
`define FIM_ID_EXT_ADDR 8'h32
`define FIM_PART0_MASK 5'h0F
`define FIM_ALL_MASK 5'h1F
`endif

// [core/fim_pkg.sv]
package fim_pkg;
    typedef enum logic [3:0] {
        FIM_IDLE = 4'b0001,
        FIM_CHECK = 4'b0010,
        FIM_RUN = 4'b0100,
        FIM_DONE = 4'b1000
    } fim_state_t;
    typedef enum logic [2:0] {
        FIM_K_IDLE = 3'b001,
        FIM_K_ONE = 3'b010,
        FIM_K_ARMED = 3'b100
    } fim_key_state_t;
    typedef enum logic [2:0] {
        FIM_FOP_NONE = 3'h0,
        FIM_FOP_CHIP = 3'h1,
        FIM_FOP_PART0 = 3'h2,
        FIM_FOP_SECTOR = 3'h3,
        FIM_FOP_PROG = 3'h4,
        FIM_FOP_READ = 3'h5
    } fim_fop_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fim_sfr_req_t;
    typedef struct packed {
        logic req;
        fim_fop_t op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fim_flash_req_t;
    typedef struct packed {
        fim_state_t st;
        logic ea_s1;
        logic ea_s2;
        logic [6:0] cmd;
        logic [7:0] data;
        logic [7:0] ah;
        logic [7:0] al;
        logic iap_en;
        logic refused;
        logic [7:0] rdata;
        fim_flash_req_t fl;
        logic osc_en;
        logic cpu_stop;
        logic clk_dbl;
        logic [3:0] ext_dis;
        logic [15:0] boot_vec;
        logic [7:0] user_vec;
        logic [7:0] id_data;
    } fim_main_t;
    typedef struct packed {
        logic [4:0][7:0] mem;
        logic [7:0] rdata;
    } fim_lock_t;
endpackage : fim_pkg

// [core/fim_key_check.sv]
`timescale 1ns/1ps
`include "fim_regs.svh"
module fim_key_check (
    // clock and reset
    input logic clock,
    input logic arst_n,
    // register access from the core
    input fim_pkg::fim_sfr_req_t sfr,
    // key sequence complete
    output logic armed
);
    import fim_pkg::*;
    fim_key_state_t st_q;
    fim_key_state_t st_d;

    // any access outside the exact key order drops the sequence
    always_comb begin
        st_d = st_q;
        if (sfr.wr && sfr.addr == `FIM_KEY1_OFS && sfr.wdata == `FIM_KEY1_VAL) begin
            st_d = FIM_K_ONE;
        end else if (sfr.wr && sfr.addr == `FIM_KEY2_OFS && sfr.wdata == `FIM_KEY2_VAL
                     && st_q == FIM_K_ONE) begin
            st_d = FIM_K_ARMED;
        end else if (sfr.wr || sfr.rd) begin
            st_d = FIM_K_IDLE;
        end
    end

    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= FIM_K_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign armed = (st_q == FIM_K_ARMED);
endmodule : fim_key_check

// [core/fim_lock_mem.sv]
`timescale 1ns/1ps
`include "fim_regs.svh"
module fim_lock_mem (
    // clock and reset
    input logic clock,
    input logic arst_n,
    // registered read port
    input logic [2:0] rd_page,
    output logic [7:0] rd_data,
    // write and bulk clear
    input logic wr_en,
    input logic [2:0] wr_page,
    input logic [7:0] wr_data,
    input logic [4:0] clr_mask
);
    import fim_pkg::*;
    fim_lock_t s_q;
    fim_lock_t s_d;

    // page security bytes, clear returns a page to erased ones
    always_comb begin
        s_d = s_q;
        s_d.rdata = (rd_page < 3'h5) ? s_q.mem[rd_page] : `FIM_LOCK_ERASED;
        if (wr_en && wr_page < 3'h5) begin
            s_d.mem[wr_page] = s_q.mem[wr_page] & wr_data;
        end
        for (int i = 0; i < 5; i++) begin
            if (clr_mask[i]) begin
                s_d.mem[i] = `FIM_LOCK_ERASED;
            end
        end
    end

    // state register, factory state is unlocked
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q.mem <= {5{`FIM_LOCK_ERASED}};
            s_q.rdata <= `FIM_LOCK_ERASED;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rdata;
endmodule : fim_lock_mem

// [core/fim_mailbox.sv]
`timescale 1ns/1ps
`include "fim_regs.svh"
module fim_mailbox #(
    parameter logic [7:0] ID_MFR = 8'h5A, // arbitrary value
    parameter logic [7:0] ID_DEV = 8'hA5, // arbitrary value
    parameter logic [7:0] ID_EXT = 8'h3C  // arbitrary value
) (
    // clock and reset
    input logic clock,
    input logic arst_n,
    // special function register access
    input fim_pkg::fim_sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    // signature read
    input logic id_rd,
    input logic [7:0] id_addr,
    output logic [7:0] id_data,
    // flash array
    output fim_pkg::fim_flash_req_t flash,
    input logic flash_done,
    input logic [7:0] flash_rdata,
    // pins and core control
    input logic external_access_pin,
    output logic cpu_stop,
    output logic osc_en,
    output logic clock_double,
    output logic [3:0] ext_disable,
    output logic [15:0] boot_vector
);
    import fim_pkg::*;
    fim_main_t s_q;
    fim_main_t s_d;
    logic armed;
    logic [2:0] rd_page;
    logic [7:0] lock_rdata;
    logic lock_wr;
    logic [7:0] lock_wdata;
    logic [4:0] lock_clr;
    logic cmd_wr;

    // ****************************************
    // helpers
    // ****************************************

    // page that an opcode touches
    function automatic logic [2:0] page_of(input logic [6:0] op, input logic [7:0] ah);
        if (op == `FIM_OP_SECURE) begin
            page_of = ah[2:0];
        end else if ({ah, 8'h00} >= `FIM_PART1_BASE) begin
            page_of = 3'h4;
        end else begin
            page_of = {1'b0, ah[5:4]};
        end
    endfunction : page_of

    // legal opcode and operand combination
    function automatic logic cmd_ok(input logic [6:0] op, input logic [7:0] dt,
                                    input logic [7:0] ah, input logic ea);
        case (op)
            `FIM_OP_CHIP: cmd_ok = (dt == `FIM_ERASE_KEY) && !ea;
            `FIM_OP_PART0: cmd_ok = (dt == `FIM_ERASE_KEY);
            `FIM_OP_SECTOR, `FIM_OP_PROG, `FIM_OP_VERIFY: cmd_ok = 1'b1;
            `FIM_OP_SECURE: cmd_ok = (ah >= `FIM_AH_PAGE0) && (ah <= `FIM_AH_PAGE4);
            `FIM_OP_EXTDIS: cmd_ok = (ah >= `FIM_AH_EXT0) && (ah <= `FIM_AH_EXT3);
            `FIM_OP_BOOTSEL: cmd_ok = (ah >= `FIM_AH_CLKDBL) && (ah <= `FIM_AH_BOOTZERO);
            `FIM_OP_USERVEC: cmd_ok = (ah == `FIM_AH_USERVEC);
            default: cmd_ok = 1'b0;
        endcase
    endfunction : cmd_ok

    // ****************************************
    // sub blocks
    // ****************************************

    // key sequence tracker
    fim_key_check u_key (
        .clock(clock),
        .arst_n(arst_n),
        .sfr(sfr),
        .armed(armed)
    );

    // page security storage
    fim_lock_mem u_lock (
        .clock(clock),
        .arst_n(arst_n),
        .rd_page(rd_page),
        .rd_data(lock_rdata),
        .wr_en(lock_wr),
        .wr_page(s_q.ah[2:0]),
        .wr_data(lock_wdata),
        .clr_mask(lock_clr)
    );

    assign cmd_wr = sfr.wr && sfr.addr == `FIM_CMD_OFS;

    // ****************************************
    // sequencer
    // ****************************************

    // register writes, command acceptance and operation steps
    always_comb begin
        s_d = s_q;
        lock_wr = 1'b0;
        lock_wdata = s_q.data;
        lock_clr = 5'h00;
        s_d.ea_s1 = external_access_pin;
        s_d.ea_s2 = s_q.ea_s1;
        if (id_rd) begin
            case (id_addr)
                `FIM_ID_MFR_ADDR: s_d.id_data = ID_MFR;
                `FIM_ID_DEV_ADDR: s_d.id_data = ID_DEV;
                `FIM_ID_EXT_ADDR: s_d.id_data = ID_EXT;
                default: s_d.id_data = 8'h00;
            endcase
        end
        if (sfr.rd) begin
            case (sfr.addr)
                `FIM_CMD_OFS: s_d.rdata = {1'b0, s_q.cmd};
                `FIM_CFG_OFS: s_d.rdata = {1'b0, s_q.iap_en, 6'h00};
                `FIM_DATA_OFS: s_d.rdata = s_q.data;
                `FIM_AH_OFS: s_d.rdata = s_q.ah;
                `FIM_AL_OFS: s_d.rdata = s_q.al;
                `FIM_STAT_OFS: s_d.rdata = {6'h00, s_q.refused, s_q.st != FIM_IDLE};
                default: s_d.rdata = 8'h00;
            endcase
        end
        if (sfr.wr) begin
            case (sfr.addr)
                `FIM_CFG_OFS: s_d.iap_en = sfr.wdata[`FIM_CFG_IAP_BIT];
                `FIM_DATA_OFS: s_d.data = sfr.wdata;
                `FIM_AH_OFS: s_d.ah = sfr.wdata;
                `FIM_AL_OFS: s_d.al = sfr.wdata;
                `FIM_STAT_OFS: begin
                    if (sfr.wdata[`FIM_STAT_REFUSED_BIT]) begin
                        s_d.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        case (s_q.st)
            FIM_IDLE: begin
                if (cmd_wr && s_q.iap_en && armed) begin
                    s_d.cmd = sfr.wdata[6:0];
                    if (cmd_ok(sfr.wdata[6:0], s_q.data, s_q.ah, s_q.ea_s2)) begin
                        s_d.st = FIM_CHECK;
                        s_d.cpu_stop = 1'b1;
                    end else begin
                        s_d.refused = 1'b1;
                    end
                end
            end
            FIM_CHECK: begin
                if ((s_q.cmd == `FIM_OP_SECTOR || s_q.cmd == `FIM_OP_PROG || s_q.cmd == `FIM_OP_VERIFY)
                    && lock_rdata != `FIM_LOCK_ERASED) begin
                    s_d.refused = 1'b1;
                    s_d.st = FIM_DONE;
                end else begin
                    s_d.st = FIM_DONE;
                    case (s_q.cmd)
                        `FIM_OP_CHIP, `FIM_OP_PART0, `FIM_OP_SECTOR, `FIM_OP_PROG, `FIM_OP_VERIFY: begin
                            s_d.st = FIM_RUN;
                            s_d.fl.req = 1'b1;
                            s_d.fl.addr = {s_q.ah, s_q.al};
                            s_d.fl.wdata = s_q.data;
                            s_d.osc_en = (s_q.cmd != `FIM_OP_VERIFY);
                            case (s_q.cmd)
                                `FIM_OP_CHIP: s_d.fl.op = FIM_FOP_CHIP;
                                `FIM_OP_PART0: s_d.fl.op = FIM_FOP_PART0;
                                `FIM_OP_SECTOR: begin
                                    s_d.fl.op = FIM_FOP_SECTOR;
                                    s_d.fl.addr = {s_q.ah, s_q.al & `FIM_SECTOR_MASK};
                                end
                                `FIM_OP_PROG: s_d.fl.op = FIM_FOP_PROG;
                                default: s_d.fl.op = FIM_FOP_READ;
                            endcase
                        end
                        `FIM_OP_SECURE: begin
                            lock_wr = 1'b1;
                            lock_wdata = s_q.data;
                        end
                        `FIM_OP_EXTDIS: s_d.ext_dis[s_q.ah[1:0]] = 1'b1;
                        `FIM_OP_BOOTSEL: begin
                            case (s_q.ah)
                                `FIM_AH_CLKDBL: s_d.clk_dbl = 1'b1;
                                `FIM_AH_BOOTUSER: s_d.boot_vec = {s_q.user_vec, 8'h00};
                                default: s_d.boot_vec = 16'h0000;
                            endcase
                        end
                        default: s_d.user_vec = s_q.data;
                    endcase
                end
            end
            FIM_RUN: begin
                if (flash_done) begin
                    s_d.fl.req = 1'b0;
                    s_d.fl.op = FIM_FOP_NONE;
                    s_d.osc_en = 1'b0;
                    s_d.st = FIM_DONE;
                    case (s_q.fl.op)
                        FIM_FOP_READ: s_d.data = flash_rdata;
                        FIM_FOP_PART0: lock_clr = `FIM_PART0_MASK;
                        FIM_FOP_CHIP: begin
                            lock_clr = `FIM_ALL_MASK;
                            s_d.ext_dis = 4'h0;
                            s_d.user_vec = 8'h00;
                            s_d.boot_vec = `FIM_BOOT_DEFAULT;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FIM_DONE: begin
                s_d.cpu_stop = 1'b0;
                s_d.st = FIM_IDLE;
            end
            default: s_d.st = FIM_IDLE;
        endcase
        if (cmd_wr && s_q.st != FIM_IDLE) begin
            s_d.refused = 1'b1;
        end
    end

    // lock page looked up for the command being taken
    assign rd_page = page_of(s_d.cmd, s_q.ah);

    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= FIM_IDLE;
            s_q.fl.op <= FIM_FOP_NONE;
            s_q.boot_vec <= `FIM_BOOT_DEFAULT;
            // pin reads high until synchronised, so chip erase stays refused
            s_q.ea_s1 <= 1'b1;
            s_q.ea_s2 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign sfr_rdata = s_q.rdata;
    assign id_data = s_q.id_data;
    assign flash = s_q.fl;
    assign cpu_stop = s_q.cpu_stop;
    assign osc_en = s_q.osc_en;
    assign clock_double = s_q.clk_dbl;
    assign ext_disable = s_q.ext_dis;
    assign boot_vector = s_q.boot_vec;

    // ****************************************
    // checks
    // ****************************************

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence idle_cmd_s;
        s_q.st == FIM_IDLE && cmd_wr;
    endsequence

    sequence flash_end_s;
        s_q.st == FIM_RUN && flash_done;
    endsequence

    iap_gate_a: assert property (idle_cmd_s and !s_q.iap_en |=> s_q.st == FIM_IDLE)
        else $error("command taken while programming disabled");
    key_gate_a: assert property (idle_cmd_s and !armed |=> s_q.st == FIM_IDLE)
        else $error("command taken without key sequence");
    cmd_start_a: assert property (idle_cmd_s and s_q.iap_en && armed
                                  && cmd_ok(sfr.wdata[6:0], s_q.data, s_q.ah, s_q.ea_s2)
                                  |=> s_q.st == FIM_CHECK && cpu_stop)
        else $error("valid command did not start");
    lock_refuse_a: assert property (s_q.st == FIM_CHECK && s_q.cmd == `FIM_OP_PROG
                                    && lock_rdata != `FIM_LOCK_ERASED |=> !flash.req && s_q.refused)
        else $error("locked page operation not refused");
    stop_hold_a: assert property (s_q.st == FIM_RUN |-> cpu_stop)
        else $error("core running during flash operation");
    osc_only_a: assert property (osc_en |-> flash.req && flash.op != FIM_FOP_READ)
        else $error("oscillator on outside program or erase");
    chip_pin_a: assert property (idle_cmd_s and sfr.wdata[6:0] == `FIM_OP_CHIP && s_q.ea_s2
                                 |=> s_q.st == FIM_IDLE)
        else $error("chip erase accepted with pin high");
    chip_clear_a: assert property (flash_end_s and flash.op == FIM_FOP_CHIP
                                   |=> boot_vector == `FIM_BOOT_DEFAULT && ext_disable == 4'h0)
        else $error("chip erase left options set");
    verify_data_a: assert property (flash_end_s and flash.op == FIM_FOP_READ
                                    |=> s_q.data == $past(flash_rdata) ##1 !cpu_stop)
        else $error("verify data not captured");
    clk_dbl_a: assert property (s_q.st == FIM_CHECK && s_q.cmd == `FIM_OP_BOOTSEL
                                && s_q.ah == `FIM_AH_CLKDBL |=> clock_double)
        else $error("clock double not applied");
    busy_flag_a: assert property (s_q.st == FIM_IDLE ##1 s_q.st == FIM_CHECK
                                  |-> s_q.st != FIM_IDLE [*2])
        else $error("busy did not hold");
    // sector erase and verify on a locked page never reach the array
    lock_other_a: assert property (s_q.st == FIM_CHECK && (s_q.cmd == `FIM_OP_SECTOR || s_q.cmd == `FIM_OP_VERIFY)
                                   && lock_rdata != `FIM_LOCK_ERASED |=> !flash.req && s_q.refused)
        else $error("locked page erase or verify not refused");
    osc_on_a: assert property (flash.req && flash.op != FIM_FOP_READ |-> osc_en)
        else $error("oscillator off during program or erase");
endmodule : fim_mailbox

// [test/fim_flash_model.sv]
`timescale 1ns/1ps
// ****************************************
// flash array model
// ****************************************
module fim_flash_model #(
    parameter int DELAY = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // request from the mailbox, answer to it
    input wire fim_pkg::fim_flash_req_t flash,
    output logic flash_done,
    output logic [7:0] flash_rdata
);
    import fim_pkg::*;
    logic [7:0] mem [logic [15:0]];
    int cnt;
    // one done pulse per request after a fixed wait; read data is scrambled outside it
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            flash_done <= 1'b0;
            flash_rdata <= 8'h00;
        end else if (flash.req && !flash_done && cnt == DELAY) begin
            cnt <= 0;
            flash_done <= 1'b1;
            case (flash.op)
                FIM_FOP_CHIP, FIM_FOP_PART0: mem.delete();
                FIM_FOP_SECTOR: for (int i = 0; i < 128; i++) mem.delete({flash.addr[15:7], i[6:0]});
                FIM_FOP_PROG: mem[flash.addr] = (mem.exists(flash.addr) ? mem[flash.addr] : 8'hFF) & flash.wdata;
                default: ;
            endcase
            flash_rdata <= mem.exists(flash.addr) ? mem[flash.addr] : 8'hFF;
        end else begin
            cnt <= flash.req && !flash_done ? cnt + 1 : 0;
            flash_done <= 1'b0;
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule : fim_flash_model

// [test/tb_fim_mailbox.sv]
`timescale 1ns/1ps
`include "fim_regs.svh"
module tb_fim_mailbox;
    import fim_pkg::*;
    localparam logic [7:0] MFR = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV = 8'hA5; // arbitrary value
    localparam logic [7:0] EXT = 8'h3C; // arbitrary value
    logic clock;
    logic arst_n;
    fim_sfr_req_t sfr;
    logic [7:0] sfr_rdata;
    logic id_rd;
    logic [7:0] id_addr;
    logic [7:0] id_data;
    fim_flash_req_t flash;
    logic flash_done;
    logic [7:0] flash_rdata;
    logic ea;
    logic cpu_stop;
    logic osc_en;
    logic clock_double;
    logic [3:0] ext_disable;
    logic [15:0] boot_vector;
    int n_fail;
    int cmp_count;
    int n_req;
    logic stop_seen;
    logic osc_seen;
    logic prev_req;
    fim_flash_req_t last_req;
    logic [7:0] rv;
    logic [7:0] ids [4];
    // ****************************************
    // design and flash model
    // ****************************************
    fim_mailbox #(.ID_MFR(MFR), .ID_DEV(DEV), .ID_EXT(EXT)) fim_mailbox_i (
        .clock(clock), .arst_n(arst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .id_rd(id_rd), .id_addr(id_addr), .id_data(id_data),
        .flash(flash), .flash_done(flash_done), .flash_rdata(flash_rdata),
        .external_access_pin(ea), .cpu_stop(cpu_stop), .osc_en(osc_en),
        .clock_double(clock_double), .ext_disable(ext_disable), .boot_vector(boot_vector)
    );
    fim_flash_model #(.DELAY(4)) fim_flash_model_i (
        .clock(clock), .arst_n(arst_n), .flash(flash), .flash_done(flash_done), .flash_rdata(flash_rdata)
    );
    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // record what each operation did at the flash side
    always @(posedge clock) begin
        prev_req <= flash.req;
        if (cpu_stop === 1'b1) stop_seen <= 1'b1;
        if (osc_en === 1'b1) osc_seen <= 1'b1;
        if (flash.req === 1'b1 && prev_req !== 1'b1) n_req <= n_req + 1;
        if (flash.req === 1'b1) last_req <= flash;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // write pulse; the strobe is left up for a following write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        sfr = '0;
        rv = sfr_rdata;
        @(negedge clock);
    endtask : rd
    task automatic clr_seen;
        n_req = 0;
        stop_seen = 1'b0;
        osc_seen = 1'b0;
    endtask : clr_seen
    // operands, key pair, command, then wait out the stall
    task automatic cmd(input logic [6:0] op, input logic [7:0] ah, input logic [7:0] al, input logic [7:0] d);
        int t;
        t = 0;
        wr(`FIM_AH_OFS, ah);
        wr(`FIM_AL_OFS, al);
        wr(`FIM_DATA_OFS, d);
        clr_seen();
        wr(`FIM_KEY1_OFS, `FIM_KEY1_VAL);
        wr(`FIM_KEY2_OFS, `FIM_KEY2_VAL);
        wr(`FIM_CMD_OFS, {1'b0, op});
        sfr = '0;
        repeat (2) @(negedge clock);
        while (cpu_stop !== 1'b0 && t < 100) begin
            t++;
            @(negedge clock);
        end
        if (t >= 100) n_fail++;
    endtask : cmd
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // watchdog
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        sfr = '0;
        id_rd = 1'b0;
        id_addr = 8'h00;
        ea = 1'b1;
        arst_n = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        prev_req = 1'b0;
        last_req = '0;
        clr_seen();
        ids = '{MFR, DEV, EXT, 8'h00};
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        chk(boot_vector, 16'h4000);
        chk({clock_double, ext_disable}, 16'h0000);
        // program enable still off: command ignored
        cmd(`FIM_OP_PROG, 8'h12, 8'h34, 8'h5A);
        chk({stop_seen, n_req[7:0]}, 16'h0000);
        rd(`FIM_CMD_OFS);
        chk(rv, 8'h00);
        wr(`FIM_CFG_OFS, 8'h40);
        // key broken by another write, then a bare command
        clr_seen();
        wr(`FIM_KEY1_OFS, `FIM_KEY1_VAL);
        wr(`FIM_DATA_OFS, 8'h5A);
        wr(`FIM_KEY2_OFS, `FIM_KEY2_VAL);
        wr(`FIM_CMD_OFS, 8'h0E);
        wr(`FIM_CMD_OFS, 8'h0E);
        sfr = '0;
        repeat (4) @(negedge clock);
        chk({stop_seen, n_req[7:0]}, 16'h0000);
        // program, read back, sector erase; the issuer programs only erased bytes
        cmd(`FIM_OP_PROG, 8'h12, 8'h34, 8'h5A);
        chk({last_req.op, last_req.addr, last_req.wdata}, {FIM_FOP_PROG, 16'h1234, 8'h5A});
        chk({stop_seen, osc_seen, n_req[7:0]}, {2'b11, 8'h01});
        cmd(`FIM_OP_VERIFY, 8'h12, 8'h34, 8'h00);
        rd(`FIM_DATA_OFS);
        chk({rv, osc_seen, last_req.op}, {8'h5A, 1'b0, FIM_FOP_READ});
        cmd(`FIM_OP_SECTOR, 8'h12, 8'h34, 8'h00);
        chk({last_req.op, last_req.addr}, {FIM_FOP_SECTOR, 16'h1200});
        cmd(`FIM_OP_VERIFY, 8'h12, 8'h34, 8'h00);
        rd(`FIM_DATA_OFS);
        chk(rv, 8'hFF);
        // lock page 1: erase, program and read there are refused
        cmd(`FIM_OP_SECURE, 8'h91, 8'h00, 8'h00);
        chk(n_req[7:0], 8'h00);
        foreach (ids[i]) begin
            cmd(i == 0 ? `FIM_OP_SECTOR : i == 1 ? `FIM_OP_VERIFY : `FIM_OP_PROG, 8'h12, 8'h34, 8'h00);
            chk(n_req[7:0], 8'h00);
        end
        rd(`FIM_STAT_OFS);
        chk(rv[1:0], 2'b10);
        wr(`FIM_STAT_OFS, 8'h02);
        rd(`FIM_STAT_OFS);
        chk(rv[1:0], 2'b00);
        cmd(`FIM_OP_PROG, 8'h00, 8'h34, 8'hA5);
        chk(n_req[7:0], 8'h01);
        // partition 0 erase clears the locks of pages 0 to 3
        cmd(`FIM_OP_PART0, 8'h00, 8'h00, 8'h55);
        chk(last_req.op, FIM_FOP_PART0);
        cmd(`FIM_OP_PROG, 8'h12, 8'h34, 8'h00);
        chk(n_req[7:0], 8'h01);
        // option commands
        cmd(`FIM_OP_USERVEC, 8'hF0, 8'h00, 8'h12);
        cmd(`FIM_OP_BOOTSEL, 8'hE1, 8'h00, 8'h00);
        chk(boot_vector, 16'h1200);
        cmd(`FIM_OP_BOOTSEL, 8'hE2, 8'h00, 8'h00);
        chk(boot_vector, 16'h0000);
        for (int i = 0; i < 4; i++) cmd(`FIM_OP_EXTDIS, 8'hB0 + i[7:0], 8'h00, 8'h00);
        chk(ext_disable, 4'hF);
        cmd(`FIM_OP_BOOTSEL, 8'hE0, 8'h00, 8'h00);
        chk(clock_double, 1'b1);
        cmd(`FIM_OP_SECURE, 8'h94, 8'h00, 8'h00);
        // chip erase refused with the pin high, taken with it low
        cmd(`FIM_OP_CHIP, 8'h00, 8'h00, 8'h55);
        chk(n_req[7:0], 8'h00);
        ea = 1'b0;
        cmd(`FIM_OP_CHIP, 8'h00, 8'h00, 8'h55);
        chk({last_req.op, osc_seen}, {FIM_FOP_CHIP, 1'b1});
        chk({boot_vector, ext_disable}, {16'h4000, 4'h0});
        cmd(`FIM_OP_PROG, 8'h40, 8'h10, 8'h00);
        chk(n_req[7:0], 8'h01);
        // signature bytes
        foreach (ids[i]) begin
            id_addr = 8'h30 + i[7:0];
            id_rd = 1'b1;
            @(negedge clock);
            id_rd = 1'b0;
            chk(id_data, ids[i]);
        end
        end_sim();
    end
endmodule : tb_fim_mailbox
